// *** rtl/psm_ctrl.sv ***
// Purpose: power-saving mode sequencer with register port, clock gates and pin control
// Assumes: single 20 MHz clock; core and peripherals obey the gate outputs
// Notes: pin outputs are registered, so core strobes pass with one cycle of delay
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/10ps
// Summary of operation
// - writing mode bit zero enters idle, mode bit one enters power-down
// - idle gates core clock, oscillator, pll and peripherals keep running
// - idle holds core state by stopping its clock only
// - idle holds ports and dac, drives both strobes high
// - any enabled interrupt or hardware reset ends idle
// - power-down stops pll and core clock
// - oscillator shutdown bit decides whether oscillator runs in power-down
// - interval counter may stay clocked; other peripherals stop in power-down
// - power-down holds ports, floats dac, drives both strobes low
// - reset returns normal mode with every register at default
// - interval counter interrupt ends power-down, core resumes after entry
// - serial interrupt ends power-down only with serial wake enable
// - external interrupt zero ends power-down only with its wake enable
module psm_ctrl
    import psm_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input psm_wake_src_t irq,
    input wire logic core_ale,
    input wire logic core_program_store_strobe,
    output psm_clk_ctrl_t clk_ctrl,
    output psm_pin_ctrl_t pin_ctrl,
    output logic resume_pulse
);

    // ****************************************
    // state
    // ****************************************
    psm_state_t state_q, state_d;
    logic [7:0] power_ctrl_reg_q, power_ctrl_reg_d;
    logic [7:0] pll_config_reg_q, pll_config_reg_d;
    psm_wake_src_t wake_stat_q, wake_stat_d;
    psm_clk_ctrl_t clk_q, clk_d;
    psm_pin_ctrl_t pin_q, pin_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic resume_q, resume_d;
    logic wake_hit;
    psm_wake_src_t wake_cause;
    logic oscillator_shutdown_bit;
    logic serial_wake_enable;
    logic ext_irq_zero_wake_enable;

    assign oscillator_shutdown_bit = pll_config_reg_q[OSC_SHUT_BIT];
    assign serial_wake_enable = power_ctrl_reg_q[SER_WAKE_BIT];
    assign ext_irq_zero_wake_enable = power_ctrl_reg_q[EXTERNAL_IRQ_ZERO_WAKE_BIT];

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    psm_wake_detect u_wake (
        .clock(clock),
        .rst_b(rst_b),
        .state(state_q),
        .irq(irq),
        .serial_wake_enable(serial_wake_enable),
        .ext_irq_zero_wake_enable(ext_irq_zero_wake_enable),
        .wake_hit(wake_hit),
        .wake_cause(wake_cause)
    );

    // ****************************************
    // mode sequencer
    // ****************************************
    always_comb begin
        state_d = state_q;
        resume_d = 1'b0;
        case (state_q)
            PSM_RUN: begin
                // power-down wins when both mode bits are written together
                if (power_ctrl_reg_q[PD_BIT]) begin
                    state_d = PSM_PD;
                end else if (power_ctrl_reg_q[IDLE_BIT]) begin
                    state_d = PSM_IDLE;
                end
            end
            PSM_IDLE: begin
                if (wake_hit) begin
                    state_d = PSM_WAKE;
                end
            end
            PSM_PD: begin
                if (wake_hit) begin
                    state_d = PSM_WAKE;
                end
            end
            PSM_WAKE: begin
                // one cycle for pll and oscillator before the core clock returns
                state_d = PSM_RUN;
                resume_d = 1'b1;
            end
            default: begin
                state_d = PSM_RUN;
            end
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    always_comb begin
        power_ctrl_reg_d = power_ctrl_reg_q;
        pll_config_reg_d = pll_config_reg_q;
        wake_stat_d = wake_stat_q;
        if (wake_hit) begin
            power_ctrl_reg_d[IDLE_BIT] = 1'b0;
            power_ctrl_reg_d[PD_BIT] = 1'b0;
        end
        if (reg_wr && hit(reg_addr, PWR_CTRL_OFS)) begin
            power_ctrl_reg_d = reg_wdata & PWR_CTRL_MASK;
        end
        if (reg_wr && hit(reg_addr, PLL_CFG_OFS)) begin
            pll_config_reg_d = reg_wdata & PLL_CFG_MASK;
        end
        // write one to clear; a wake in the same cycle still sets its bit
        if (reg_wr && hit(reg_addr, WAKE_STAT_OFS)) begin
            wake_stat_d = wake_stat_q & ~psm_wake_src_t'(reg_wdata[3:0]);
        end
        if (wake_hit) begin
            wake_stat_d = wake_stat_d | wake_cause;
        end
    end

    always_comb begin
        rdata_d = '0;
        if (reg_rd) begin
            case (reg_addr)
                PWR_CTRL_OFS: rdata_d = power_ctrl_reg_q;
                PLL_CFG_OFS: rdata_d = pll_config_reg_q;
                WAKE_STAT_OFS: rdata_d = {4'h0, wake_stat_q};
                MODE_STAT_OFS: rdata_d = {1'b0, clk_q, state_q};
                default: rdata_d = '0;
            endcase
        end
    end

    // ****************************************
    // clock gates and pins
    // ****************************************
    always_comb begin
        clk_d = CLK_RST;
        pin_d.port_hold = 1'b0;
        pin_d.dac_oe = 1'b1;
        pin_d.ale = core_ale;
        pin_d.program_store_strobe = core_program_store_strobe;
        case (state_d)
            PSM_IDLE: begin
                // core state survives because only its clock stops
                clk_d.core_clk_en = 1'b0;
                pin_d.port_hold = 1'b1;
                pin_d.ale = 1'b1;
                pin_d.program_store_strobe = 1'b1;
            end
            PSM_PD: begin
                clk_d.core_clk_en = 1'b0;
                clk_d.pll_en = 1'b0;
                // next register value, so a write during power-down moves the gate at once
                clk_d.osc_en = !pll_config_reg_d[OSC_SHUT_BIT];
                clk_d.periph_clk_en = 1'b0;
                // interval counter runs from the oscillator, so it stops with it
                clk_d.tic_clk_en = !pll_config_reg_d[OSC_SHUT_BIT];
                pin_d.port_hold = 1'b1;
                pin_d.dac_oe = 1'b0;
                pin_d.ale = 1'b0;
                pin_d.program_store_strobe = 1'b0;
            end
            PSM_WAKE: begin
                clk_d.core_clk_en = 1'b0;
                pin_d.port_hold = 1'b1;
                pin_d.ale = 1'b1;
                pin_d.program_store_strobe = 1'b1;
            end
            default: begin
                clk_d = CLK_RST;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= PSM_RUN;
            power_ctrl_reg_q <= PWR_CTRL_RST;
            pll_config_reg_q <= PLL_CFG_RST;
            wake_stat_q <= WAKE_STAT_RST;
            clk_q <= CLK_RST;
            pin_q <= PIN_RST;
            rdata_q <= '0;
            resume_q <= 1'b0;
        end else begin
            state_q <= state_d;
            power_ctrl_reg_q <= power_ctrl_reg_d;
            pll_config_reg_q <= pll_config_reg_d;
            wake_stat_q <= wake_stat_d;
            clk_q <= clk_d;
            pin_q <= pin_d;
            rdata_q <= rdata_d;
            resume_q <= resume_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign clk_ctrl = clk_q;
    assign pin_ctrl = pin_q;
    assign resume_pulse = resume_q;

    // ****************************************
    // checks
    // ****************************************
    sequence s_wake_exit;
        state_q == PSM_WAKE ##1 (state_q == PSM_RUN && resume_pulse);
    endsequence

    sequence s_run_with_pd;
        state_q == PSM_RUN && power_ctrl_reg_q[PD_BIT];
    endsequence

    pd_entry_a: assert property (@(posedge clock) disable iff (!rst_b)
        s_run_with_pd |=> state_q == PSM_PD)
        else $error("power-down bit did not enter power-down");

    idle_entry_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state_q == PSM_RUN && power_ctrl_reg_q[IDLE_BIT] && !power_ctrl_reg_q[PD_BIT])
        |=> state_q == PSM_IDLE)
        else $error("idle bit did not enter idle");

    idle_clocks_a: assert property (@(posedge clock) disable iff (!rst_b)
        state_q == PSM_IDLE |-> (!clk_ctrl.core_clk_en && clk_ctrl.pll_en
        && clk_ctrl.osc_en && clk_ctrl.periph_clk_en))
        else $error("idle clock gating wrong");

    core_frozen_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state_q == PSM_IDLE)[*2] |-> $stable(clk_ctrl) && !clk_ctrl.core_clk_en)
        else $error("core clock moved during idle");

    idle_pins_a: assert property (@(posedge clock) disable iff (!rst_b)
        state_q == PSM_IDLE |-> (pin_ctrl.ale && pin_ctrl.program_store_strobe
        && pin_ctrl.port_hold && pin_ctrl.dac_oe))
        else $error("idle pin states wrong");

    idle_wake_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state_q == PSM_IDLE && irq.any_irq) |=> s_wake_exit)
        else $error("enabled interrupt did not end idle");

    pd_clocks_a: assert property (@(posedge clock) disable iff (!rst_b)
        state_q == PSM_PD |-> (!clk_ctrl.core_clk_en && !clk_ctrl.pll_en
        && clk_ctrl.osc_en == !pll_config_reg_q[OSC_SHUT_BIT]))
        else $error("power-down clock gating wrong");

    pd_periph_a: assert property (@(posedge clock) disable iff (!rst_b)
        state_q == PSM_PD |-> (!clk_ctrl.periph_clk_en
        && clk_ctrl.tic_clk_en == clk_ctrl.osc_en))
        else $error("power-down peripheral gating wrong");

    pd_pins_a: assert property (@(posedge clock) disable iff (!rst_b)
        state_q == PSM_PD |-> (!pin_ctrl.ale && !pin_ctrl.program_store_strobe
        && !pin_ctrl.dac_oe && pin_ctrl.port_hold))
        else $error("power-down pin states wrong");

    tic_wake_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state_q == PSM_PD && irq.interval_counter) |=> s_wake_exit)
        else $error("interval counter did not end power-down");

    mode_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state_q != PSM_RUN && wake_hit && !reg_wr)
        |=> !power_ctrl_reg_q[IDLE_BIT] && !power_ctrl_reg_q[PD_BIT])
        else $error("mode bits not cleared on wake");

    osc_shut_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state_q == PSM_PD && oscillator_shutdown_bit)
        |-> (!clk_ctrl.osc_en && !clk_ctrl.tic_clk_en))
        else $error("oscillator ran in power-down while shut down");

    serial_wake_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state_q == PSM_PD && irq.serial && serial_wake_enable) |=> s_wake_exit)
        else $error("enabled serial interrupt did not end power-down");

    external_irq_zero_wake_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state_q == PSM_PD && irq.external_irq_zero && ext_irq_zero_wake_enable) |=> s_wake_exit)
        else $error("enabled external_irq_zero did not end power-down");

    pd_stay_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state_q == PSM_PD && !wake_hit) |=> state_q == PSM_PD)
        else $error("power-down left without a wake event");

    wake_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
        state_q == PSM_WAKE |-> (!clk_ctrl.core_clk_en && pin_ctrl.port_hold
        && pin_ctrl.ale && pin_ctrl.program_store_strobe))
        else $error("core clock or pins moved before resume");

    resume_src_a: assert property (@(posedge clock) disable iff (!rst_b)
        resume_pulse |-> $past(state_q) == PSM_WAKE)
        else $error("resume pulse without a wake cycle");

    run_clocks_a: assert property (@(posedge clock) disable iff (!rst_b)
        state_q == PSM_RUN |-> clk_ctrl == CLK_RST)
        else $error("normal mode clock gates wrong");

    run_pins_a: assert property (@(posedge clock) disable iff (!rst_b)
        state_q == PSM_RUN |-> (pin_ctrl.dac_oe && !pin_ctrl.port_hold))
        else $error("normal mode port or dac control wrong");

endmodule : psm_ctrl

// *** rtl/psm_pkg.sv ***
// Purpose: shared constants and types of the power-saving mode controller
// Assumes: 8-bit register port, 4-bit word address
// Notes: register offsets are word indices on the plain register port
package psm_pkg;

    // ****************************************
    // register port and map
    // ****************************************
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam logic [3:0] PWR_CTRL_OFS = 4'h0;
    localparam logic [3:0] PLL_CFG_OFS = 4'h1;
    localparam logic [3:0] WAKE_STAT_OFS = 4'h2;
    localparam logic [3:0] MODE_STAT_OFS = 4'h3;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int IDLE_BIT = 0;
    localparam int PD_BIT = 1;
    localparam int SER_WAKE_BIT = 2;
    localparam int EXTERNAL_IRQ_ZERO_WAKE_BIT = 3;
    localparam int OSC_SHUT_BIT = 0;
    localparam logic [7:0] PWR_CTRL_MASK = 8'h0F;
    localparam logic [7:0] PLL_CFG_MASK = 8'h01;
    localparam logic [7:0] PWR_CTRL_RST = 8'h00;
    localparam logic [7:0] PLL_CFG_RST = 8'h00;
    localparam logic [3:0] WAKE_STAT_RST = 4'h0;

    // ****************************************
    // states and carriers
    // ****************************************
    typedef enum logic [1:0] {
        PSM_RUN = 2'b00,
        PSM_IDLE = 2'b01,
        PSM_PD = 2'b11,
        PSM_WAKE = 2'b10
    } psm_state_t;

    typedef struct packed {
        logic interval_counter;
        logic serial;
        logic external_irq_zero;
        logic any_irq;
    } psm_wake_src_t;

    typedef struct packed {
        logic core_clk_en;
        logic pll_en;
        logic osc_en;
        logic periph_clk_en;
        logic tic_clk_en;
    } psm_clk_ctrl_t;

    typedef struct packed {
        logic port_hold;
        logic dac_oe;
        logic ale;
        logic program_store_strobe;
    } psm_pin_ctrl_t;

    localparam psm_clk_ctrl_t CLK_RST = 5'h1F;
    localparam psm_pin_ctrl_t PIN_RST = 4'h7;

endpackage : psm_pkg

// *** rtl/psm_wake_detect.sv ***
// Purpose: decides which events end the current low-power state
// Assumes: interrupt request inputs are levels synchronous to clock
// Notes: combinational; the sequencer registers the outcome
`timescale 1ns/10ps
module psm_wake_detect
    import psm_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input psm_state_t state,
    input psm_wake_src_t irq,
    input wire logic serial_wake_enable,
    input wire logic ext_irq_zero_wake_enable,
    output logic wake_hit,
    output psm_wake_src_t wake_cause
);

    always_comb begin
        wake_cause = '0;
        case (state)
            PSM_IDLE: begin
                wake_cause.any_irq = irq.any_irq;
            end
            PSM_PD: begin
                wake_cause.interval_counter = irq.interval_counter;
                wake_cause.serial = irq.serial & serial_wake_enable;
                wake_cause.external_irq_zero = irq.external_irq_zero & ext_irq_zero_wake_enable;
            end
            default: begin
                wake_cause = '0;
            end
        endcase
        wake_hit = |wake_cause;
    end

    serial_gate_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state == PSM_PD && !serial_wake_enable && !irq.interval_counter && !irq.external_irq_zero) |-> !wake_hit)
        else $error("serial event woke power-down while disabled");
    external_irq_zero_gate_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state == PSM_PD && irq.external_irq_zero && ext_irq_zero_wake_enable) |-> wake_hit)
        else $error("enabled external_irq_zero did not wake power-down");

endmodule : psm_wake_detect

// *** test/psm_ctrl_tb_top.sv ***
// Purpose: self-checking bench of the power-saving mode controller
// Assumes: bench drives every port itself; register reads answer one cycle later
// Notes: each task starts and ends just after a rising edge; outputs sampled on falling edges
`timescale 1ns/10ps
module psm_ctrl_tb_top;
    import psm_pkg::*;

    // ****************************************
    // stimulus and bookkeeping
    // ****************************************
    logic clock;
    logic rst_b;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    psm_wake_src_t irq;
    logic core_ale;
    logic core_program_store_strobe;
    psm_clk_ctrl_t clk_ctrl;
    psm_pin_ctrl_t pin_ctrl;
    logic resume_pulse;
    int fail_count;
    int comparisons;

    psm_ctrl dut (
        .clock(clock),
        .rst_b(rst_b),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .irq(irq),
        .core_ale(core_ale),
        .core_program_store_strobe(core_program_store_strobe),
        .clk_ctrl(clk_ctrl),
        .pin_ctrl(pin_ctrl),
        .resume_pulse(resume_pulse)
    );

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // ****************************************
    // compare, bus and closing tasks
    // ****************************************
    task automatic cmp_data(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_data

    task automatic cmp_pins(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_pins

    task automatic summarize();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        // idle edge so a following write never re-drives the strobe in one step
        @(posedge clock);
    endtask : wr

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string name);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        cmp_data(name, exp, reg_rdata);
        @(posedge clock);
        @(negedge clock);
        cmp_data("rdata after read", 8'h00, reg_rdata);
        @(posedge clock);
    endtask : rd_chk

    // clock gates and pin levels of the present state
    task automatic chk_state(input logic [4:0] exp_clk, input logic [3:0] exp_pin);
        @(negedge clock);
        cmp_pins("clk_ctrl", {3'h0, exp_clk}, {3'h0, clk_ctrl});
        cmp_pins("pin_ctrl", {4'h0, exp_pin}, {4'h0, pin_ctrl});
        @(posedge clock);
    endtask : chk_state

    // one-cycle interrupt level, then the wake outcome two edges later
    task automatic wake_try(input logic [3:0] src, input logic hit);
        irq <= psm_wake_src_t'(src);
        @(posedge clock);
        irq <= psm_wake_src_t'(4'h0);
        @(negedge clock);
        cmp_pins("core_clk_en in wake", 8'h00, {7'h00, clk_ctrl.core_clk_en});
        @(posedge clock);
        @(negedge clock);
        cmp_pins("resume_pulse", {7'h00, hit}, {7'h00, resume_pulse});
        cmp_pins("core_clk_en", {7'h00, hit}, {7'h00, clk_ctrl.core_clk_en});
        @(posedge clock);
        @(negedge clock);
        cmp_pins("resume_pulse end", 8'h00, {7'h00, resume_pulse});
        @(posedge clock);
    endtask : wake_try

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_defaults();
        core_ale <= 1'b1;
        core_program_store_strobe <= 1'b0;
        @(posedge clock);
        chk_state(5'h1F, 4'h6);
        rd_chk(PWR_CTRL_OFS, 8'h00, "power_ctrl_reg");
        rd_chk(PLL_CFG_OFS, 8'h00, "pll_config_reg");
        rd_chk(WAKE_STAT_OFS, 8'h00, "wake status");
        wr(4'hA, 8'hFF);
        rd_chk(4'hA, 8'h00, "unmapped");
        rd_chk(PWR_CTRL_OFS, 8'h00, "power_ctrl_reg after stray write");
    endtask : t_defaults

    task automatic t_idle();
        core_ale <= 1'b0;
        core_program_store_strobe <= 1'b0;
        wr(PWR_CTRL_OFS, 8'h01);
        @(posedge clock);
        chk_state(5'h0F, 4'hF);
        rd_chk(MODE_STAT_OFS, 8'h3D, "mode status idle");
        wake_try(4'h1, 1'b1);
        chk_state(5'h1F, 4'h4);
        rd_chk(PWR_CTRL_OFS, 8'h00, "idle bit cleared");
        rd_chk(WAKE_STAT_OFS, 8'h01, "wake cause any");
        wr(WAKE_STAT_OFS, 8'h0F);
        rd_chk(WAKE_STAT_OFS, 8'h00, "wake status cleared");
    endtask : t_idle

    task automatic t_pd_osc_on();
        core_ale <= 1'b1;
        core_program_store_strobe <= 1'b1;
        wr(PWR_CTRL_OFS, 8'h02);
        @(posedge clock);
        chk_state(5'h05, 4'h8);
        rd_chk(MODE_STAT_OFS, 8'h17, "mode status pd");
        wake_try(4'h1, 1'b0);
        wake_try(4'h4, 1'b0);
        wake_try(4'h2, 1'b0);
        chk_state(5'h05, 4'h8);
        wake_try(4'h8, 1'b1);
        rd_chk(PWR_CTRL_OFS, 8'h00, "pd bit cleared");
        rd_chk(WAKE_STAT_OFS, 8'h08, "wake cause tic");
        wr(WAKE_STAT_OFS, 8'h0F);
    endtask : t_pd_osc_on

    task automatic t_pd_osc_off();
        wr(PLL_CFG_OFS, 8'h01);
        wr(PWR_CTRL_OFS, 8'h06);
        @(posedge clock);
        chk_state(5'h00, 4'h8);
        wake_try(4'h4, 1'b1);
        rd_chk(PWR_CTRL_OFS, 8'h04, "enable kept, pd cleared");
        rd_chk(WAKE_STAT_OFS, 8'h04, "wake cause serial");
        wr(WAKE_STAT_OFS, 8'h0F);
        wr(PWR_CTRL_OFS, 8'h0A);
        @(posedge clock);
        wake_try(4'h4, 1'b0);
        wake_try(4'h2, 1'b1);
        rd_chk(WAKE_STAT_OFS, 8'h02, "wake cause external_irq_zero");
    endtask : t_pd_osc_off

    // reset pin in the middle of power-down
    task automatic t_reset_in_pd();
        // both mode bits at once: power-down wins
        wr(PWR_CTRL_OFS, 8'h03);
        @(posedge clock);
        chk_state(5'h00, 4'h8);
        rst_b <= 1'b0;
        chk_state(5'h1F, 4'h7);
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        @(posedge clock);
        chk_state(5'h1F, 4'h7);
        rd_chk(PWR_CTRL_OFS, 8'h00, "power_ctrl_reg after reset");
        rd_chk(PLL_CFG_OFS, 8'h00, "pll_config_reg after reset");
        rd_chk(WAKE_STAT_OFS, 8'h00, "wake status after reset");
    endtask : t_reset_in_pd

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        fail_count = 0;
        comparisons = 0;
        rst_b = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        irq = psm_wake_src_t'(4'h0);
        core_ale = 1'b1;
        core_program_store_strobe = 1'b1;
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        t_defaults();
        t_idle();
        t_pd_osc_on();
        t_pd_osc_off();
        t_reset_in_pd();
        summarize();
    end

    // whole run is under two hundred cycles
    initial begin
        repeat (4000) @(posedge clock);
        fail_count++;
        summarize();
    end

endmodule : psm_ctrl_tb_top
